// [include/gauge_pkg.sv]
// Purpose: Shared constants and types for the capacity accounting core
// Assumes: Register port is byte wide with a seven-bit address
// Notes:   Full counts are kept as the upper byte of the 16-bit count
package gauge_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [6:0] OFS_COMMAND_WORD  = 7'h00;
    localparam logic [6:0] OFS_PRIMARY_FLAGS = 7'h01;
    localparam logic [6:0] OFS_THERMAL       = 7'h02;
    localparam logic [6:0] OFS_NOMINAL       = 7'h03;
    localparam logic [6:0] OFS_PACK_LABEL    = 7'h04;
    localparam logic [6:0] OFS_CUR_SCALE_LO  = 7'h05;
    localparam logic [6:0] OFS_CUR_SCALE_HI  = 7'h06;
    localparam logic [6:0] OFS_STRAP_PD      = 7'h07;
    localparam logic [6:0] OFS_STRAP_PU      = 7'h08;
    localparam logic [6:0] OFS_BATT_VOLT     = 7'h0b;
    localparam logic [6:0] OFS_EMPTY_THRESH  = 7'h0c;
    localparam logic [6:0] OFS_REL_COMP      = 7'h0d;
    localparam logic [6:0] OFS_COMP_LO       = 7'h0e;
    localparam logic [6:0] OFS_COMP_HI       = 7'h0f;
    localparam logic [6:0] OFS_FULL_COUNT    = 7'h10;
    localparam logic [6:0] OFS_FULL_NOMINAL  = 7'h11;
    localparam logic [6:0] OFS_PEAK_RATE     = 7'h12;
    localparam logic [6:0] OFS_PRESENT_RATE  = 7'h13;
    localparam logic [6:0] OFS_DISCH_LO      = 7'h2e;
    localparam logic [6:0] OFS_DISCH_HI      = 7'h2f;

    // ****************************************
    // Commands, field positions, reset values
    // ****************************************
    localparam logic [7:0] CMD_CP_RELEASE = 8'h55;
    localparam logic [7:0] CMD_CP_LOW     = 8'h66;
    localparam logic [7:0] CMD_REINIT     = 8'h78;
    localparam int         FLG_INIT_POS   = 7;
    localparam int         FLG_CPIN_POS   = 4;
    localparam int         FLG_EDV1_POS   = 1;
    localparam int         FLG_EDVF_POS   = 0;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [7:0] RST_THRESH     = 8'h00;
    localparam logic [23:0] PERCENT       = 24'h000064;
    localparam logic [23:0] COMP_MAX      = 24'h00ffff;

    // Full count upper bytes, index = pin1 level * 3 + pin2 level
    localparam logic [0:8][7:0] FULL_COUNT_TBL = {
        8'hbc, 8'hb4, 8'ha9, 8'h9c, 8'h96, 8'h8d, 8'h7c, 8'h71, 8'h66};

    // Temperature row floors in degrees C
    localparam logic signed [7:0] TEMP_ROW1 = -8'sd10;
    localparam logic signed [7:0] TEMP_ROW2 = 8'sd0;
    localparam logic signed [7:0] TEMP_ROW3 = 8'sd21;
    localparam logic signed [7:0] TEMP_ROW4 = 8'sd55;
    localparam logic signed [7:0] TEMP_ROW5 = 8'sd70;

    // Rate column floors, present-rate register units
    localparam logic [7:0] RATE_COL_C80 = 8'h02;
    localparam logic [7:0] RATE_COL_C25 = 8'h06;
    localparam logic [7:0] RATE_COL_C10 = 8'h10;
    localparam logic [7:0] RATE_COL_C5  = 8'h20;
    localparam logic [7:0] RATE_COL_C3  = 8'h35;

    // Efficiency percent, row = temperature, column = rate
    localparam logic [0:35][7:0] EFF_FLOAT = {
        8'h61, 8'h63, 8'h60, 8'h5c, 8'h55, 8'h51,
        8'h62, 8'h62, 8'h61, 8'h5e, 8'h59, 8'h55,
        8'h62, 8'h62, 8'h61, 8'h5e, 8'h5a, 8'h57,
        8'h63, 8'h63, 8'h62, 8'h60, 8'h5c, 8'h59,
        8'h63, 8'h63, 8'h62, 8'h60, 8'h5d, 8'h5a,
        8'h63, 8'h63, 8'h62, 8'h60, 8'h5d, 8'h5a};
    localparam logic [0:35][7:0] EFF_LOW = {
        8'h57, 8'h55, 8'h50, 8'h46, 8'h35, 8'h32,
        8'h5d, 8'h5b, 8'h58, 8'h50, 8'h44, 8'h33,
        8'h60, 8'h5e, 8'h5b, 8'h55, 8'h4a, 8'h3c,
        8'h63, 8'h61, 8'h5f, 8'h59, 8'h51, 8'h44,
        8'h64, 8'h63, 8'h61, 8'h5c, 8'h55, 8'h4a,
        8'h65, 8'h64, 8'h62, 8'h5d, 8'h56, 8'h4c};
    localparam logic [0:35][7:0] EFF_HIGH = {
        8'h5c, 8'h5d, 8'h5c, 8'h58, 8'h53, 8'h4b,
        8'h62, 8'h62, 8'h61, 8'h5d, 8'h59, 8'h51,
        8'h64, 8'h64, 8'h63, 8'h60, 8'h5b, 8'h54,
        8'h68, 8'h68, 8'h66, 8'h63, 8'h5f, 8'h58,
        8'h6a, 8'h6a, 8'h69, 8'h64, 8'h61, 8'h5a,
        8'h6b, 8'h6b, 8'h69, 8'h65, 8'h62, 8'h5b};

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {LVL_HIGH, LVL_FLOAT, LVL_LOW} strap_lvl_t;
    typedef enum logic [1:0] {DISP_TWO, DISP_FOUR, DISP_FIVE} disp_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        strap_lvl_t eff_table;
        strap_lvl_t scale;
        disp_mode_t disp;
        logic       start_full;
    } strap_cfg_t;
endpackage

// [design/gauge_capacity_core.sv]
// Purpose: Capacity accounting core of a primary-cell gas gauge
// Assumes: Register requests come from a serial front end on i_core_clk
// Notes:   Strap sense bits come from pads and are synchronised here
//
// Function
// RULE1 - Keep user full capacity in 8-bit full count register, scaled units.
// RULE2 - Full nominal capacity changes only by host write after initialization.
// RULE3 - Full nominal capacity is 8 bits, same scaled units as full count.
// RULE4 - Cumulative discharge held in 16-bit discharge count register.
// RULE5 - Compensated capacity equals efficiency factor times full nominal minus discharge.
// RULE6 - Hold peak discharge rate, expose at 12h, use it for efficiency.
// RULE7 - Temperature part of efficiency recomputed continuously, never held.
// RULE8 - Sample six three-level straps at each initialization and latch them.
// RULE9 - Strap-selected full count appears in read-only register at 10h.
// RULE10 - Strap pin 4 picks one of three efficiency tables per cycle.
// RULE11 - Efficiency percentages indexed by temperature and rate columns 0 to C/3.
// RULE12 - Strap pin 5 selects two, four or five segment display mode.
// RULE13 - Strap pin 5 floating selects five segment display.
// RULE14 - At initialization full nominal gets full count if pin 6 high, else zero.
// RULE15 - Host writes full nominal capacity when it was initialized to zero.
// RULE16 - Compensated capacity read as low byte 0eh and high byte 0fh.
// RULE17 - Unlisted addresses and reserved bits are reserved.
// RULE18 - Pins 1,2 choose full count 48128..26112; pin 3 chooses scale.
// RULE19 - Each detected discharge unit increments the discharge count; code drops a unit arriving with a host write to 2Eh/2Fh.
// RULE20 - Nominal capacity equals full nominal capacity minus discharge count.
// RULE21 - Startup flag set when loaded from full count, cleared when zero.
// RULE22 - Compensated capacity clamps at zero, never wraps negative.
// RULE23 - Initialization clears held peak rate and discharge count.
`timescale 1ns/1ps

module gauge_capacity_core (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire gauge_pkg::reg_req_t   i_reg_req,
    input  wire logic [5:0]            i_strap_pd_hi,
    input  wire logic [5:0]            i_strap_pu_lo,
    input  wire logic                  i_disch_unit,
    input  wire logic [7:0]            i_rate,
    input  wire logic signed [7:0]     i_temp,
    input  wire logic [15:0]           i_cur_scale,
    input  wire logic [7:0]            i_batt_volt,
    input  wire logic                  i_edv1,
    input  wire logic                  i_edvf,
    output logic [7:0]                 o_reg_rdata,
    output logic                       o_reg_rvalid,
    output logic                       o_cp_oe,
    output logic [7:0]                 o_empty_thresh,
    output logic [15:0]                o_comp_capacity,
    output gauge_pkg::strap_cfg_t      o_cfg,
    output logic                       o_cfg_valid
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic gauge_pkg::strap_lvl_t dec_lvl(input logic pd_hi, input logic pu_lo);
        if (pd_hi) begin
            dec_lvl = gauge_pkg::LVL_HIGH;
        end else if (pu_lo) begin
            dec_lvl = gauge_pkg::LVL_LOW;
        end else begin
            dec_lvl = gauge_pkg::LVL_FLOAT;
        end
    endfunction

    // ****************************************
    // Strap synchronisers
    // ****************************************
    logic [11:0]             sync1_ff;
    logic [11:0]             sync2_ff;
    logic [11:0]             sync3_ff;
    gauge_pkg::strap_lvl_t   lvl [6];

    // No reset: chain keeps sampling so the power-up latch sees real pins
    always_ff @(posedge i_core_clk) begin
        sync1_ff <= {i_strap_pu_lo, i_strap_pd_hi};
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_lvl
            assign lvl[gi] = dec_lvl(sync3_ff[gi], sync3_ff[gi+6]);
        end
    endgenerate

    // ****************************************
    // Initialization and strap latch
    // ****************************************
    logic                  wr_cmd;
    logic                  init_pend_ff;
    logic                  init_pulse;
    logic [7:0]            full_count_ff;
    logic [7:0]            pd_stat_ff;
    logic [7:0]            pu_stat_ff;
    logic                  init_flag_ff;
    logic [3:0]            fc_idx;

    assign wr_cmd     = i_reg_req.wr && (i_reg_req.addr == gauge_pkg::OFS_COMMAND_WORD);
    // Waits for straps to settle so a pad still moving is not latched
    assign init_pulse = init_pend_ff && (sync2_ff == sync3_ff);
    assign fc_idx     = 4'(lvl[0]) * 4'h3 + 4'(lvl[1]);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            init_pend_ff <= 1'b1;
        end else if (wr_cmd && i_reg_req.wdata == gauge_pkg::CMD_REINIT) begin
            init_pend_ff <= 1'b1;
        end else if (init_pulse) begin
            init_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            full_count_ff <= gauge_pkg::RST_BYTE;
            pd_stat_ff    <= gauge_pkg::RST_BYTE;
            pu_stat_ff    <= gauge_pkg::RST_BYTE;
            init_flag_ff  <= 1'b0;
            o_cfg         <= '{gauge_pkg::LVL_FLOAT, gauge_pkg::LVL_FLOAT,
                               gauge_pkg::DISP_FIVE, 1'b0};
            o_cfg_valid   <= 1'b0;
        end else if (init_pulse) begin
            // RULE8 latch all straps
            pd_stat_ff    <= {2'b00, sync3_ff[5:0]};
            pu_stat_ff    <= {2'b00, sync3_ff[11:6]};
            o_cfg_valid   <= 1'b1;
            // RULE18 full count and scale
            // RULE9 full count register
            // RULE1 8-bit scaled full count
            full_count_ff <= gauge_pkg::FULL_COUNT_TBL[fc_idx];
            o_cfg.scale   <= lvl[2];
            // RULE10 efficiency table held
            o_cfg.eff_table <= lvl[3];
            // RULE12 display mode select
            // RULE13 float gives five segments
            case (lvl[4])
                gauge_pkg::LVL_HIGH:  o_cfg.disp <= gauge_pkg::DISP_FOUR;
                gauge_pkg::LVL_LOW:   o_cfg.disp <= gauge_pkg::DISP_TWO;
                default:              o_cfg.disp <= gauge_pkg::DISP_FIVE;
            endcase
            o_cfg.start_full <= (lvl[5] == gauge_pkg::LVL_HIGH);
            // RULE21 startup flag
            init_flag_ff  <= (lvl[5] == gauge_pkg::LVL_HIGH);
        end
    end

    // ****************************************
    // Capacity registers
    // ****************************************
    logic [7:0]   full_nom_ff;
    logic [15:0]  disch_cnt_ff;
    logic [7:0]   peak_ff;
    logic [7:0]   label_ff;
    logic         cpin_ff;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            full_nom_ff <= gauge_pkg::RST_BYTE;
        end else if (init_pulse) begin
            // RULE14 initial full nominal
            full_nom_ff <= (lvl[5] == gauge_pkg::LVL_HIGH) ?
                           gauge_pkg::FULL_COUNT_TBL[fc_idx] : gauge_pkg::RST_BYTE;
        end else if (i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_FULL_NOMINAL) begin
            // RULE2 host write only
            // RULE15 manual pack setup
            full_nom_ff <= i_reg_req.wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || init_pulse) begin
            // RULE23 fresh discharge cycle
            disch_cnt_ff <= gauge_pkg::RST_WORD;
        end else if (i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_DISCH_LO) begin
            disch_cnt_ff <= {disch_cnt_ff[15:8], i_reg_req.wdata};
        end else if (i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_DISCH_HI) begin
            disch_cnt_ff <= {i_reg_req.wdata, disch_cnt_ff[7:0]};
        end else if (i_disch_unit) begin
            // RULE19 count discharge units
            // RULE4 16-bit count, wraps at top
            disch_cnt_ff <= disch_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || init_pulse) begin
            peak_ff <= gauge_pkg::RST_BYTE;
        end else if (i_rate > peak_ff) begin
            // RULE6 peak hold of rate
            peak_ff <= i_rate;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            label_ff       <= gauge_pkg::RST_BYTE;
            o_empty_thresh <= gauge_pkg::RST_THRESH;
        end else if (i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_PACK_LABEL) begin
            label_ff <= i_reg_req.wdata;
        end else if (i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_EMPTY_THRESH) begin
            o_empty_thresh <= i_reg_req.wdata;
        end
    end

    // Open-drain control pin: enable pulls the pin low
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cpin_ff <= 1'b1;
            o_cp_oe <= 1'b0;
        end else if (wr_cmd && i_reg_req.wdata == gauge_pkg::CMD_CP_RELEASE) begin
            cpin_ff <= 1'b1;
            o_cp_oe <= 1'b0;
        end else if (wr_cmd && i_reg_req.wdata == gauge_pkg::CMD_CP_LOW) begin
            cpin_ff <= 1'b0;
            o_cp_oe <= 1'b1;
        end
    end

    // ****************************************
    // Efficiency and compensated capacity
    // ****************************************
    logic [2:0]   row;
    logic [2:0]   col;
    logic [5:0]   eff_idx;
    logic [7:0]   eff_pct;
    logic [23:0]  comp_full;
    logic [23:0]  nxt_comp;
    logic [16:0]  nominal;

    always_comb begin
        // RULE7 live temperature row
        if (i_temp >= gauge_pkg::TEMP_ROW5)      row = 3'd5;
        else if (i_temp >= gauge_pkg::TEMP_ROW4) row = 3'd4;
        else if (i_temp >= gauge_pkg::TEMP_ROW3) row = 3'd3;
        else if (i_temp >= gauge_pkg::TEMP_ROW2) row = 3'd2;
        else if (i_temp >= gauge_pkg::TEMP_ROW1) row = 3'd1;
        else                                     row = 3'd0;
        // RULE6 held rate picks column
        if (peak_ff >= gauge_pkg::RATE_COL_C3)       col = 3'd5;
        else if (peak_ff >= gauge_pkg::RATE_COL_C5)  col = 3'd4;
        else if (peak_ff >= gauge_pkg::RATE_COL_C10) col = 3'd3;
        else if (peak_ff >= gauge_pkg::RATE_COL_C25) col = 3'd2;
        else if (peak_ff >= gauge_pkg::RATE_COL_C80) col = 3'd1;
        else                                         col = 3'd0;
    end

    // Widen first: row 5 times 6 does not fit three bits
    assign eff_idx = 6'(row) * 6'd6 + {3'b000, col};

    // RULE11 percent lookup
    always_comb begin
        case (o_cfg.eff_table)
            gauge_pkg::LVL_HIGH: eff_pct = gauge_pkg::EFF_HIGH[eff_idx];
            gauge_pkg::LVL_LOW:  eff_pct = gauge_pkg::EFF_LOW[eff_idx];
            default:             eff_pct = gauge_pkg::EFF_FLOAT[eff_idx];
        endcase
    end

    // RULE3 full nominal as count upper byte
    // RULE5 factor times full nominal
    assign comp_full = ({16'h0000, eff_pct} * {8'h00, full_nom_ff, 8'h00}) / gauge_pkg::PERCENT;

    always_comb begin
        // RULE22 clamp at zero
        if (comp_full <= {8'h00, disch_cnt_ff}) begin
            nxt_comp = 24'h000000;
        end else if (comp_full - {8'h00, disch_cnt_ff} > gauge_pkg::COMP_MAX) begin
            nxt_comp = gauge_pkg::COMP_MAX;
        end else begin
            nxt_comp = comp_full - {8'h00, disch_cnt_ff};
        end
    end

    // RULE20 nominal is full nominal minus count
    assign nominal = {1'b0, full_nom_ff, 8'h00} - {1'b0, disch_cnt_ff};

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_comp_capacity <= gauge_pkg::RST_WORD;
        end else begin
            o_comp_capacity <= nxt_comp[15:0];
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        case (i_reg_req.addr)
            gauge_pkg::OFS_PRIMARY_FLAGS: begin
                nxt_rdata[gauge_pkg::FLG_INIT_POS] = init_flag_ff;
                nxt_rdata[gauge_pkg::FLG_CPIN_POS] = cpin_ff;
                nxt_rdata[gauge_pkg::FLG_EDV1_POS] = i_edv1;
                nxt_rdata[gauge_pkg::FLG_EDVF_POS] = i_edvf;
            end
            gauge_pkg::OFS_THERMAL:      nxt_rdata = i_temp;
            gauge_pkg::OFS_NOMINAL:      nxt_rdata = nominal[16] ? 8'h00 : nominal[15:8];
            gauge_pkg::OFS_PACK_LABEL:   nxt_rdata = label_ff;
            gauge_pkg::OFS_CUR_SCALE_LO: nxt_rdata = i_cur_scale[7:0];
            gauge_pkg::OFS_CUR_SCALE_HI: nxt_rdata = i_cur_scale[15:8];
            gauge_pkg::OFS_STRAP_PD:     nxt_rdata = pd_stat_ff;
            gauge_pkg::OFS_STRAP_PU:     nxt_rdata = pu_stat_ff;
            gauge_pkg::OFS_BATT_VOLT:    nxt_rdata = i_batt_volt;
            gauge_pkg::OFS_EMPTY_THRESH: nxt_rdata = o_empty_thresh;
            // RULE16 byte split of capacity
            gauge_pkg::OFS_COMP_LO:      nxt_rdata = o_comp_capacity[7:0];
            gauge_pkg::OFS_COMP_HI:      nxt_rdata = o_comp_capacity[15:8];
            gauge_pkg::OFS_FULL_COUNT:   nxt_rdata = full_count_ff;
            gauge_pkg::OFS_FULL_NOMINAL: nxt_rdata = full_nom_ff;
            gauge_pkg::OFS_PEAK_RATE:    nxt_rdata = peak_ff;
            gauge_pkg::OFS_PRESENT_RATE: nxt_rdata = i_rate;
            gauge_pkg::OFS_DISCH_LO:     nxt_rdata = disch_cnt_ff[7:0];
            gauge_pkg::OFS_DISCH_HI:     nxt_rdata = disch_cnt_ff[15:8];
            // RULE17 reserved reads as zero
            default:                     nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_req.rd;
            o_reg_rdata  <= i_reg_req.rd ? nxt_rdata : 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_peak_no_fall: assert property ( // RULE6
        !$past(init_pulse) && !$past(i_rst) |-> peak_ff >= $past(peak_ff))
        else $error("Peak rate fell without initialization");
    a_peak_cleared: assert property ( // RULE23
        init_pulse |=> peak_ff == 8'h00 && disch_cnt_ff == 16'h0000)
        else $error("Initialization left peak or count set");
    a_count_step: assert property ( // RULE19
        i_disch_unit && !init_pulse && !i_reg_req.wr
        |=> disch_cnt_ff == $past(disch_cnt_ff) + 16'h0001)
        else $error("Discharge unit not counted");
    a_full_nom_hold: assert property ( // RULE2
        !init_pulse && !(i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_FULL_NOMINAL)
        |=> $stable(full_nom_ff))
        else $error("Full nominal changed by itself");
    a_full_nom_init: assert property ( // RULE14
        init_pulse ##1 init_flag_ff |-> full_nom_ff == full_count_ff)
        else $error("Full nominal not loaded from full count");
    a_flag_zero: assert property ( // RULE21
        init_pulse ##1 !init_flag_ff |-> full_nom_ff == 8'h00)
        else $error("Startup flag clear but full nominal not zero");
    a_five_seg: assert property ( // RULE13
        init_pulse && lvl[4] == gauge_pkg::LVL_FLOAT |=> o_cfg.disp == gauge_pkg::DISP_FIVE)
        else $error("Floating pin did not give five segments");
    a_comp_clamp: assert property ( // RULE22
        comp_full <= {8'h00, disch_cnt_ff} |=> o_comp_capacity == 16'h0000)
        else $error("Compensated capacity wrapped negative");
    a_comp_read: assert property ( // RULE16
        i_reg_req.rd && i_reg_req.addr == gauge_pkg::OFS_COMP_HI
        |=> o_reg_rvalid && o_reg_rdata == $past(o_comp_capacity[15:8]))
        else $error("Capacity high byte read wrong");
    a_reserved_read: assert property ( // RULE17
        i_reg_req.rd && i_reg_req.addr == 7'h20 |=> o_reg_rdata == 8'h00)
        else $error("Reserved address read non-zero");
    a_full_cnt_read: assert property ( // RULE9
        i_reg_req.rd && i_reg_req.addr == gauge_pkg::OFS_FULL_COUNT
        |=> o_reg_rdata == $past(full_count_ff))
        else $error("Full count read wrong");

    c_reinit: cover property (
        wr_cmd && i_reg_req.wdata == gauge_pkg::CMD_REINIT ##[1:8] init_pulse);
    c_peak_rise: cover property (i_rate > peak_ff ##1 peak_ff != 8'h00);
    c_comp_zero: cover property (o_comp_capacity != 16'h0000 ##1 o_comp_capacity == 16'h0000);
    c_full_nom_write: cover property (
        i_reg_req.wr && i_reg_req.addr == gauge_pkg::OFS_FULL_NOMINAL);

endmodule

// [tb/host_model.sv]
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, one idle edge between requests
// Notes:   Read data is judged by the bench, not here
`timescale 1ns/1ps

module host_model (
    input  wire logic           i_core_clk,
    output gauge_pkg::reg_req_t o_req
);
    initial o_req = '0;

    // ******
    // Request
    // ******
    // one read or write transfer, strobe held for one cycle
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_core_clk);
        o_req <= '0;
    endtask
endmodule

// [tb/gauge_capacity_core_tb.sv]
// Purpose: Self-checking bench for the capacity core
// Assumes: Reads are answered in order, one result each
// Notes:   Expected read bytes wait in a queue for the monitor
`timescale 1ns/1ps

module gauge_capacity_core_tb;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_disch_unit = 1'b0;
    logic [7:0] i_rate = 8'h00;
    logic signed [7:0] i_temp = 8'sd25;
    logic [5:0][1:0] lv = '0;
    logic [5:0] i_strap_pd_hi, i_strap_pu_lo;
    logic [7:0] exp_q[$];
    logic [7:0] exp_full, o_reg_rdata, o_empty_thresh;
    logic [15:0] cc, o_comp_capacity;
    logic sf, o_reg_rvalid, o_cp_oe, o_cfg_valid;
    int fails = 0, samples_checked = 0, cyc = 0, seed = 32'h63ed7641;
    gauge_pkg::reg_req_t i_reg_req;
    gauge_pkg::strap_cfg_t o_cfg;

    always #20 i_core_clk = ~i_core_clk;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            i_strap_pd_hi[i] = lv[i] == 2'd0;
            i_strap_pu_lo[i] = lv[i] == 2'd2;
        end
    end

    gauge_capacity_core dut (.i_core_clk, .i_rst, .i_reg_req, .i_strap_pd_hi, .i_strap_pu_lo,
        .i_disch_unit, .i_rate, .i_temp, .i_cur_scale(16'h0000), .i_batt_volt(8'h00),
        .i_edv1(1'b1), .i_edvf(1'b0), .o_reg_rdata, .o_reg_rvalid, .o_cp_oe,
        .o_empty_thresh, .o_comp_capacity, .o_cfg, .o_cfg_valid);
    host_model host (.i_core_clk, .o_req(i_reg_req));

    // ******
    // Checking
    // ******
    task automatic chk(string n, logic [15:0] x, logic [15:0] g);
        samples_checked++;
        if (x !== g) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] x);
        exp_q.push_back(x);
        host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic stop_test();
        // Reads never answered are mismatches
        if (exp_q.size() != 0) fails++;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (o_reg_rvalid === 1'b1) chk("read data", exp_q.pop_front(), o_reg_rdata);
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end
    function automatic int eff(int i);
        case (lv[3])
            2'd0: return gauge_pkg::EFF_HIGH[i];
            2'd1: return gauge_pkg::EFF_FLOAT[i];
            default: return gauge_pkg::EFF_LOW[i];
        endcase
    endfunction

    // ******
    // Scenarios
    // ******
    task automatic setup(int k);
        i_rate <= 8'h00;
        @(posedge i_core_clk);
        for (int i = 0; i < 3; i++) lv[i] <= 2'($unsigned($random(seed)) % 3);
        lv[5:3] <= {2'(k), 2'((k + 1) % 3), 2'(k)};
        host.xfer(1'b1, 7'h00, gauge_pkg::CMD_REINIT);
        repeat (10) @(posedge i_core_clk);
        exp_full = gauge_pkg::FULL_COUNT_TBL[lv[0] * 3 + lv[1]];
        sf = lv[5] == 2'd0;
        chk("table", lv[3], o_cfg.eff_table);
        chk("scale", lv[2], o_cfg.scale);
        chk("display", (lv[4] + 2'd1) % 3, o_cfg.disp);
        chk("start full", sf, o_cfg.start_full);
        rd(7'h10, exp_full);
        rd(7'h11, sf ? exp_full : 8'h00);
        rd(7'h01, {sf, 7'h12});
        rd(7'h12, 8'h00);
        rd(7'h2e, 8'h00);
    endtask

    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk("power-up start", 1'b1, o_cfg.start_full);
        chk("power-up table", 2'd0, o_cfg.eff_table);
        chk("cfg valid", 1'b1, o_cfg_valid);
        for (int k = 0; k < 3; k++) begin
            i_rate <= 8'($random(seed));
            repeat (2) @(posedge i_core_clk);
            setup(k);
        end
        host.xfer(1'b1, 7'h11, 8'h40);
        i_rate <= 8'h20;
        for (int n = 0; n < 3; n++) begin
            @(posedge i_core_clk);
            i_disch_unit <= 1'b1;
            @(posedge i_core_clk);
            i_disch_unit <= 1'b0;
            i_rate <= 8'h05;
        end
        rd(7'h12, 8'h20);
        rd(7'h2e, 8'h03);
        rd(7'h11, 8'h40);
        rd(7'h03, 8'h3f);
        for (int r = 3; r >= 0; r -= 3) begin
            i_temp <= r ? 8'sd25 : -8'sd30;
            repeat (3) @(posedge i_core_clk);
            cc = 16'(eff(r * 6 + 4) * 32'h4000 / 100 - 3);
            rd(7'h0e, cc[7:0]);
            rd(7'h0f, cc[15:8]);
        end
        host.xfer(1'b1, 7'h2e, 8'hff);
        host.xfer(1'b1, 7'h2f, 8'hff);
        repeat (2) @(negedge i_core_clk);
        chk("comp", 16'h0000, o_comp_capacity);
        host.xfer(1'b1, 7'h10, 8'h00);
        rd(7'h10, exp_full);
        rd(7'h09, 8'h00);
        rd(7'h20, 8'h00);
        host.xfer(1'b1, 7'h0c, 8'h5a);
        rd(7'h0c, 8'h5a);
        chk("threshold", 8'h5a, o_empty_thresh);
        rd(7'h13, 8'h05);
        host.xfer(1'b1, 7'h00, gauge_pkg::CMD_CP_LOW);
        rd(7'h01, {sf, 7'h02});
        @(negedge i_core_clk);
        chk("cp enable", 1'b1, o_cp_oe);
        repeat (3) @(posedge i_core_clk);
        stop_test();
    end
endmodule
